// file: include/ipc_pkg.sv
package ipc_pkg;
	// ****************************************
	// Bus geometry
	// ****************************************
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 16;

	// ****************************************
	// Register indices (byte address = index * 4)
	// ****************************************
	localparam logic [ADDR_W-1:0] IDX_PRIORITY_SELECT = 20'h07055;
	localparam logic [ADDR_W-1:0] IDX_STATUS_SUMMARY  = 20'h070A0;
	localparam logic [ADDR_W-1:0] IDX_MISC_CONTROL    = 20'h070A8;
	localparam logic [ADDR_W-1:0] IDX_SOURCE_ENABLE   = 20'h070B0;
	localparam logic [ADDR_W-1:0] IDX_MODE_CONTROL    = 20'h070B1;
	localparam logic [ADDR_W-1:0] IDX_SERVICE_STATE   = 20'h070B2;

	// ****************************************
	// Reset values and writable masks
	// ****************************************
	localparam logic [REG_W-1:0] RST_PRIORITY_SELECT = 16'h0000;
	localparam logic [REG_W-1:0] RST_MISC_CONTROL    = 16'h0000;
	localparam logic [REG_W-1:0] RST_SOURCE_ENABLE   = 16'h0000;
	localparam logic [REG_W-1:0] MASK_PRIORITY       = 16'hEFF7;
	localparam logic [REG_W-1:0] MASK_MISC           = 16'hF800;
	localparam logic [REG_W-1:0] MASK_SRC_ENABLE     = 16'h67F7;
	localparam logic [REG_W-1:0] MASK_W1C            = 16'h9800;

	// ****************************************
	// Status bit positions
	// ****************************************
	localparam int unsigned BIT_KEY   = 15;
	localparam int unsigned BIT_UART  = 14;
	localparam int unsigned BIT_SPI   = 13;
	localparam int unsigned BIT_EXT1  = 12;
	localparam int unsigned BIT_EXT0  = 11;
	localparam int unsigned BIT_ADC   = 10;
	localparam int unsigned BIT_MCP4  = 9;
	localparam int unsigned BIT_MCP3  = 8;
	localparam int unsigned BIT_TPM2  = 7;
	localparam int unsigned BIT_PDC1  = 6;
	localparam int unsigned BIT_PDC0  = 5;
	localparam int unsigned BIT_CMT   = 4;
	localparam int unsigned BIT_OL    = 2;
	localparam int unsigned BIT_OSC   = 1;
	localparam int unsigned BIT_FAULT = 0;

	// Misc control fields, plus the nest bit of mode control
	localparam int unsigned BIT_KEY_EN   = 15;
	localparam int unsigned BIT_EXT1_RISE = 14;
	localparam int unsigned BIT_EXT0_RISE = 13;
	localparam int unsigned BIT_EXT1_EN  = 12;
	localparam int unsigned BIT_EXT0_EN  = 11;
	localparam int unsigned BIT_NEST     = 0;

	// Normal level of each status bit, 3 bits per bit position
	localparam logic [47:0] LEVEL_MAP = {3'd7, 3'd6, 3'd6, 3'd5, 3'd5, 3'd7, 3'd3, 3'd3,
	                                     3'd4, 3'd2, 3'd1, 3'd7, 3'd0, 3'd0, 3'd0, 3'd0};

	// ****************************************
	// Vector numbers and timing
	// ****************************************
	localparam logic [3:0] VEC_FAST  = 4'h8;
	localparam logic [3:0] VEC_BREAK = 4'h9;
	localparam int unsigned FILTER_SAMPLES = 4;
	localparam logic [2:0] FILTER_LAST = 3'(FILTER_SAMPLES - 1);

	typedef enum logic [1:0] {
		IPC_BUS_IDLE   = 2'b00,
		IPC_BUS_ACCESS = 2'b01,
		IPC_BUS_DONE   = 2'b10
	} ipc_bus_state_t;
endpackage : ipc_pkg

// file: core/ipc_ext_filter.sv
`timescale 1ns/1ps
module ipc_ext_filter
	import ipc_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Pin side
	input  wire logic pin,
	input  wire logic sample_en,
	input  wire logic rising_sel,
	// Event out
	output logic      edge_pulse
);
	logic       sync1_ff;
	logic       sync2_ff;
	logic       last_ff;
	logic [2:0] run_ff;
	logic       level_ff;
	logic       level_d_ff;

	// ****************************************
	// Synchroniser
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= pin;
			sync2_ff <= sync1_ff;
		end
	end

	// ****************************************
	// Glitch filter on half-rate samples
	// ****************************************
	// Level only moves after four equal samples in a row
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_ff  <= 1'b0;
			run_ff   <= 3'h0;
			level_ff <= 1'b0;
		end else if (sample_en) begin
			last_ff <= sync2_ff;
			if (sync2_ff != last_ff) begin
				run_ff <= 3'h0;
			end else if (run_ff < FILTER_LAST) begin
				run_ff <= run_ff + 3'h1;
			end
			if (sync2_ff == last_ff && run_ff >= FILTER_LAST - 3'h1) begin
				level_ff <= sync2_ff;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_d_ff <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			level_d_ff <= level_ff;
			edge_pulse <= rising_sel ? (level_ff & ~level_d_ff) : (~level_ff & level_d_ff);
		end
	end
endmodule : ipc_ext_filter

// file: core/ipc_core.sv
`timescale 1ns/1ps
module ipc_core
	import ipc_pkg::*;
(
	// APB slave
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Peripheral flags, same clock
	input  wire logic              fault_input_one,
	input  wire logic              fault_input_two,
	input  wire logic [1:0]        output_short,
	input  wire logic              overload_input_one,
	input  wire logic              overload_input_two,
	input  wire logic              clock_monitor_event,
	input  wire logic [6:0]        position_ch0_src,
	input  wire logic [6:0]        position_ch1_src,
	input  wire logic [1:0]        motor_ch3_src,
	input  wire logic [1:0]        motor_ch4_src,
	input  wire logic [2:0]        pwm_ch2_src,
	input  wire logic [1:0]        uart_src,
	input  wire logic [1:0]        spi_src,
	input  wire logic              conversion_done,
	input  wire logic [1:0]        compare_match_src,
	input  wire logic              key_change_event,
	// External pins, asynchronous
	input  wire logic              external_pin_zero,
	input  wire logic              external_pin_one,
	// Processor side
	input  wire logic              soft_break,
	input  wire logic              accept_break,
	input  wire logic              accept_fast,
	input  wire logic              accept_normal,
	input  wire logic              return_done,
	output logic                   break_req,
	output logic                   fast_req,
	output logic                   normal_req,
	output logic      [2:0]        normal_level,
	output logic      [3:0]        vector_index,
	output logic      [9:0]        service_state
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [REG_W-1:0] priority_select_ff;
	logic [REG_W-1:0] misc_control_ff;
	logic [REG_W-1:0] source_enable_ff;
	logic             nest_mode_ff;
	logic [REG_W-1:0] mirror_ff;
	logic             key_flag_ff;
	logic             ext0_flag_ff;
	logic             ext1_flag_ff;
	logic             half_en_ff;
	logic             ext0_edge;
	logic             ext1_edge;
	logic [REG_W-1:0] status_word;
	logic [REG_W-1:0] enable_word;
	logic [REG_W-1:0] select_word;
	logic [7:0]       level_pend;
	logic             fast_pend;
	logic [7:0]       in_service_ff;
	logic             fast_active_ff;
	logic             break_active_ff;
	logic             break_pend_ff;
	logic [2:0]       win_level;
	logic [2:0]       top_active;
	logic             may_normal;
	logic             bus_commit;
	logic             wr_commit;
	logic [REG_W-1:0] wdata16;
	logic [REG_W-1:0] nxt_rdata;
	logic             nxt_err;
	ipc_bus_state_t   bus_state_ff;

	// Lowest set bit index, bit 0 winning
	function automatic logic [2:0] first_set(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'd7;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : first_set

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
		return a == ADDR_W'(idx << 2);
	endfunction : hit

	// ****************************************
	// Half-rate sample enable
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_en_ff <= 1'b0;
		end else begin
			half_en_ff <= ~half_en_ff;
		end
	end

	ipc_ext_filter u_ext0 (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin        (external_pin_zero),
		.sample_en  (half_en_ff),
		.rising_sel (misc_control_ff[BIT_EXT0_RISE]),
		.edge_pulse (ext0_edge)
	);

	ipc_ext_filter u_ext1 (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin        (external_pin_one),
		.sample_en  (half_en_ff),
		.rising_sel (misc_control_ff[BIT_EXT1_RISE]),
		.edge_pulse (ext1_edge)
	);

	// ****************************************
	// APB handshake: one wait state
	// ****************************************
	assign bus_commit = (bus_state_ff == IPC_BUS_ACCESS) & psel & penable;
	assign wr_commit  = bus_commit & pwrite & ~nxt_err;
	assign wdata16    = pwdata[REG_W-1:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_state_ff <= IPC_BUS_IDLE;
		end else begin
			case (bus_state_ff)
				IPC_BUS_IDLE:   bus_state_ff <= (psel & ~penable) ? IPC_BUS_ACCESS : IPC_BUS_IDLE;
				IPC_BUS_ACCESS: bus_state_ff <= (psel & penable) ? IPC_BUS_DONE : IPC_BUS_ACCESS;
				IPC_BUS_DONE:   bus_state_ff <= IPC_BUS_IDLE;
				default:        bus_state_ff <= IPC_BUS_IDLE;
			endcase
		end
	end

	always_comb begin
		nxt_rdata = '0;
		nxt_err   = 1'b0;
		if (hit(paddr, IDX_PRIORITY_SELECT)) begin
			nxt_rdata = priority_select_ff;
		end else if (hit(paddr, IDX_STATUS_SUMMARY)) begin
			nxt_rdata = status_word;
		end else if (hit(paddr, IDX_MISC_CONTROL)) begin
			nxt_rdata = misc_control_ff;
		end else if (hit(paddr, IDX_SOURCE_ENABLE)) begin
			nxt_rdata = source_enable_ff;
		end else if (hit(paddr, IDX_MODE_CONTROL)) begin
			nxt_rdata = {15'h0000, nest_mode_ff};
		end else if (hit(paddr, IDX_SERVICE_STATE)) begin
			nxt_rdata = {6'h00, break_active_ff, fast_active_ff, in_service_ff};
		end else begin
			nxt_err = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= bus_commit;
			pslverr <= bus_commit & nxt_err;
			prdata  <= (bus_commit & ~pwrite) ? {16'h0000, nxt_rdata} : '0;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			priority_select_ff <= RST_PRIORITY_SELECT;
			misc_control_ff    <= RST_MISC_CONTROL;
			source_enable_ff   <= RST_SOURCE_ENABLE;
			nest_mode_ff       <= 1'b0;
		end else if (wr_commit) begin
			if (hit(paddr, IDX_PRIORITY_SELECT)) begin
				priority_select_ff <= wdata16 & MASK_PRIORITY;
			end
			if (hit(paddr, IDX_MISC_CONTROL)) begin
				misc_control_ff <= wdata16 & MASK_MISC;
			end
			if (hit(paddr, IDX_SOURCE_ENABLE)) begin
				source_enable_ff <= wdata16 & MASK_SRC_ENABLE;
			end
			if (hit(paddr, IDX_MODE_CONTROL)) begin
				nest_mode_ff <= wdata16[BIT_NEST];
			end
		end
	end

	// ****************************************
	// Status summary
	// ****************************************
	// Mirrored bits follow the peripheral flags; no clear path here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mirror_ff <= '0;
		end else begin
			mirror_ff                <= '0;
			mirror_ff[BIT_FAULT]     <= fault_input_one | fault_input_two | (|output_short);
			mirror_ff[BIT_OL]        <= overload_input_one | overload_input_two;
			mirror_ff[BIT_OSC]       <= clock_monitor_event;
			mirror_ff[BIT_PDC0]      <= |position_ch0_src;
			mirror_ff[BIT_PDC1]      <= |position_ch1_src;
			mirror_ff[BIT_MCP3]      <= |motor_ch3_src;
			mirror_ff[BIT_MCP4]      <= |motor_ch4_src;
			mirror_ff[BIT_TPM2]      <= |pwm_ch2_src;
			mirror_ff[BIT_UART]      <= |uart_src;
			mirror_ff[BIT_SPI]       <= |spi_src;
			mirror_ff[BIT_ADC]       <= conversion_done;
			mirror_ff[BIT_CMT]       <= |compare_match_src;
		end
	end

	// Sticky flags: an event in the clearing cycle wins, enables ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_flag_ff  <= 1'b0;
			ext0_flag_ff <= 1'b0;
			ext1_flag_ff <= 1'b0;
		end else begin
			key_flag_ff  <= key_change_event | (key_flag_ff &
			                ~(wr_commit & hit(paddr, IDX_STATUS_SUMMARY) & wdata16[BIT_KEY]));
			ext0_flag_ff <= ext0_edge | (ext0_flag_ff &
			                ~(wr_commit & hit(paddr, IDX_STATUS_SUMMARY) & wdata16[BIT_EXT0]));
			ext1_flag_ff <= ext1_edge | (ext1_flag_ff &
			                ~(wr_commit & hit(paddr, IDX_STATUS_SUMMARY) & wdata16[BIT_EXT1]));
		end
	end

	always_comb begin
		status_word            = mirror_ff & ~MASK_W1C;
		status_word[BIT_KEY]   = key_flag_ff;
		status_word[BIT_EXT0]  = ext0_flag_ff;
		status_word[BIT_EXT1]  = ext1_flag_ff;
	end

	// ****************************************
	// Routing to levels
	// ****************************************
	always_comb begin
		enable_word            = source_enable_ff & MASK_SRC_ENABLE;
		enable_word[BIT_KEY]   = misc_control_ff[BIT_KEY_EN];
		enable_word[BIT_EXT1]  = misc_control_ff[BIT_EXT1_EN];
		enable_word[BIT_EXT0]  = misc_control_ff[BIT_EXT0_EN];
		// One select bit covers both external pins
		select_word            = priority_select_ff;
		select_word[BIT_EXT1]  = priority_select_ff[BIT_EXT0];
		level_pend             = '0;
		fast_pend              = 1'b0;
		for (int i = 0; i < REG_W; i++) begin
			if (status_word[i] & enable_word[i]) begin
				if (select_word[i]) begin
					fast_pend = 1'b1;
				end else begin
					level_pend[LEVEL_MAP[i*3 +: 3]] = 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Arbitration
	// ****************************************
	assign win_level  = first_set(level_pend);
	assign top_active = first_set(in_service_ff);
	// Without nesting any normal in service blocks every other normal
	assign may_normal = (|level_pend) & ~fast_active_ff & ~break_active_ff &
	                    ((in_service_ff == 8'h00) | (nest_mode_ff & (win_level < top_active)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_pend_ff <= 1'b0;
		end else begin
			break_pend_ff <= soft_break | (break_pend_ff & ~(accept_break & break_req));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_req    <= 1'b0;
			fast_req     <= 1'b0;
			normal_req   <= 1'b0;
			normal_level <= 3'd0;
			vector_index <= 4'h0;
		end else begin
			break_req    <= break_pend_ff & ~accept_break & ~break_active_ff;
			fast_req     <= fast_pend & ~fast_active_ff & ~break_active_ff & ~accept_fast;
			normal_req   <= may_normal & ~accept_normal;
			normal_level <= win_level;
			// Same terms as the break and fast requests, so an accepted break or fast never lingers here
			if (break_pend_ff & ~accept_break & ~break_active_ff) begin
				vector_index <= VEC_BREAK;
			end else if (fast_pend & ~fast_active_ff & ~break_active_ff & ~accept_fast) begin
				vector_index <= VEC_FAST;
			end else begin
				vector_index <= {1'b0, win_level};
			end
		end
	end

	// ****************************************
	// Service tracking
	// ****************************************
	// Return always unwinds the most urgent active service
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_service_ff   <= 8'h00;
			fast_active_ff  <= 1'b0;
			break_active_ff <= 1'b0;
		end else begin
			if (return_done) begin
				if (break_active_ff) begin
					break_active_ff <= 1'b0;
				end else if (fast_active_ff) begin
					fast_active_ff <= 1'b0;
				end else if (in_service_ff != 8'h00) begin
					in_service_ff[top_active] <= 1'b0;
				end
			end
			if (accept_break & break_req) begin
				break_active_ff <= 1'b1;
			end
			if (accept_fast & fast_req) begin
				fast_active_ff <= 1'b1;
			end
			if (accept_normal & normal_req) begin
				in_service_ff[normal_level] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Service state out
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			service_state <= 10'h000;
		end else begin
			service_state <= {break_active_ff, fast_active_ff, in_service_ff};
		end
	end
endmodule : ipc_core

// file: tb/ipc_props.sv
`timescale 1ns/1ps
module ipc_props
	import ipc_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic [DATA_W-1:0] prdata,
	input  wire logic              pready,
	input  wire logic              pslverr,
	// Processor side
	input  wire logic              accept_break,
	input  wire logic              accept_normal,
	input  wire logic              break_req,
	input  wire logic              fast_req,
	input  wire logic              normal_req,
	input  wire logic [3:0]        vector_index,
	input  wire logic [9:0]        service_state
);
	// ****************************************
	// Bus and request checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	a_apb_one_wait: assert property (s_setup ##1 s_access |=> pready)
		else $error("access not answered after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_idle_data_zero: assert property (!pready |-> prdata == '0)
		else $error("prdata not zero outside answer");
	a_break_vector: assert property (break_req |-> vector_index == VEC_BREAK)
		else $error("break vector wrong");
	a_fast_vector: assert property (fast_req && !break_req |-> vector_index == VEC_FAST)
		else $error("fast vector wrong");
	a_normal_drop: assert property (accept_normal && normal_req |=> !normal_req)
		else $error("normal request held after acceptance");
	a_service_entry: assert property (accept_normal && normal_req |-> ##[1:2] (|service_state[7:0]))
		else $error("accepted level not in service");
	a_fast_blocks: assert property (service_state[8] && $past(service_state[8]) |-> !normal_req && !fast_req)
		else $error("request raised during fast service");
	a_break_latched: assert property (break_req && !accept_break |=> break_req)
		else $error("break request lost before acceptance");
endmodule : ipc_props

bind ipc_core ipc_props props_u (.*);

// file: tb/ipc_cpu_model.sv
`timescale 1ns/1ps
module ipc_cpu_model (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Bench control, stalls acceptance
	input  wire logic hold,
	// Requests
	input  wire logic break_req,
	input  wire logic fast_req,
	input  wire logic normal_req,
	// Acceptance pulses
	output logic      accept_break,
	output logic      accept_fast,
	output logic      accept_normal
);
	// Most urgent only; one pulse, then the request must drop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accept_break  <= 1'b0;
			accept_fast   <= 1'b0;
			accept_normal <= 1'b0;
		end else begin
			accept_break  <= break_req & ~accept_break & ~hold;
			accept_fast   <= fast_req & ~break_req & ~accept_fast & ~hold;
			accept_normal <= normal_req & ~break_req & ~fast_req & ~accept_normal & ~hold;
		end
	end
endmodule : ipc_cpu_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench
	import ipc_pkg::*;
;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hold;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic              fault_input_one, fault_input_two, overload_input_one, overload_input_two;
	logic              clock_monitor_event, conversion_done, key_change_event, soft_break, return_done;
	logic              external_pin_zero, external_pin_one, accept_break, accept_fast, accept_normal;
	logic              break_req, fast_req, normal_req;
	logic [1:0]        output_short, motor_ch3_src, motor_ch4_src, uart_src, spi_src, compare_match_src;
	logic [2:0]        pwm_ch2_src, normal_level;
	logic [6:0]        position_ch0_src, position_ch1_src;
	logic [3:0]        vector_index;
	logic [9:0]        service_state;
	logic [34:0]       src;
	int                error_cnt, num_checks;

	assign {compare_match_src, conversion_done, spi_src, uart_src, pwm_ch2_src, motor_ch4_src, motor_ch3_src,
		position_ch1_src, position_ch0_src, clock_monitor_event, overload_input_two, overload_input_one,
		output_short, fault_input_two, fault_input_one} = src;

	ipc_core dut_u (.*);
	ipc_cpu_model cpu_u (.*);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task finish_test;
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task fail_wait;
		error_cnt++;
		$display("[ERR] %0t wait timed out", $time);
		finish_test;
	endtask : fail_wait

	// Holds the request until pready is seen at an edge
	task apb(input logic w, input logic [ADDR_W-1:0] idx, input logic [REG_W-1:0] wd);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx[ADDR_W-3:0], 2'b00};
		pwdata  <= {16'h0000, wd};
		n = 0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			fail_wait;
	endtask : apb

	task rchk(input logic [ADDR_W-1:0] idx, input logic [REG_W-1:0] exp);
		apb(1'b0, idx, 16'h0000);
		chk(rd, {16'h0000, exp});
	endtask : rchk

	// k: 0 break, 1 fast, 2 normal
	task wait_for(input int k, input logic v);
		int n;
		n = 0;
		while (n < 200 && ((k == 0) ? break_req : (k == 1) ? fast_req : normal_req) !== v) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 200)
			fail_wait;
	endtask : wait_for

	task pulse_ret;
		@(posedge pclk);
		return_done <= 1'b1;
		@(posedge pclk);
		return_done <= 1'b0;
	endtask : pulse_ret

	// {level, status bit} of each bit of src
	function automatic logic [6:0] src_map(input int i);
		if (i < 4) return 7'h00;
		if (i < 6) return 7'h02;
		if (i == 6) return 7'h01;
		if (i < 14) return 7'h15;
		if (i < 21) return 7'h26;
		if (i < 23) return 7'h38;
		if (i < 25) return 7'h39;
		if (i < 28) return 7'h47;
		if (i < 30) return 7'h6E;
		if (i < 32) return 7'h6D;
		if (i == 32) return 7'h7A;
		return 7'h74;
	endfunction : src_map

	// ****************************************
	// Scenarios
	// ****************************************
	task s_regs;
		rchk(IDX_PRIORITY_SELECT, 16'h0000);
		rchk(IDX_MISC_CONTROL, 16'h0000);
		apb(1'b1, IDX_PRIORITY_SELECT, 16'h9008);
		rchk(IDX_PRIORITY_SELECT, 16'h8000);
		apb(1'b1, IDX_PRIORITY_SELECT, 16'h0000);
		apb(1'b0, 20'h07000, 16'h0000);
		chk({31'h0, err}, 32'h1);
	endtask : s_regs

	// Enables all off: flags still visible for polling
	task s_poll;
		src <= 35'h100000000;
		rchk(IDX_STATUS_SUMMARY, 16'h0400);
		chk({31'h0, normal_req}, 32'h0);
		apb(1'b1, IDX_STATUS_SUMMARY, 16'h0400);
		rchk(IDX_STATUS_SUMMARY, 16'h0400);
		@(posedge pclk);
		key_change_event <= 1'b1;
		@(posedge pclk);
		key_change_event <= 1'b0;
		apb(1'b1, IDX_STATUS_SUMMARY, 16'h0000);
		rchk(IDX_STATUS_SUMMARY, 16'h8400);
		apb(1'b1, IDX_STATUS_SUMMARY, 16'h8000);
		rchk(IDX_STATUS_SUMMARY, 16'h0400);
		src <= '0;
	endtask : s_poll

	task s_map;
		logic [6:0] m;
		hold <= 1'b1;
		apb(1'b1, IDX_SOURCE_ENABLE, 16'h67F7);
		for (int i = 0; i < 35; i++) begin
			m = src_map(i);
			src <= 35'h1 << i;
			wait_for(2, 1'b1);
			chk({29'h0, normal_level}, {29'h0, m[6:4]});
			rchk(IDX_STATUS_SUMMARY, 16'h0001 << m[3:0]);
			src <= '0;
			wait_for(2, 1'b0);
		end
		apb(1'b1, IDX_SOURCE_ENABLE, 16'h0120);
		hold <= 1'b0;
	endtask : s_map

	task s_nest;
		hold <= 1'b1;
		src <= 35'h000200080;
		wait_for(2, 1'b1);
		chk({29'h0, normal_level}, 32'h1);
		chk({28'h0, vector_index}, 32'h1);
		hold <= 1'b0;
		wait_for(2, 1'b0);
		repeat (10) @(posedge pclk);
		chk({31'h0, normal_req}, 32'h0);
		chk({22'h0, service_state}, 32'h0002);
		src <= 35'h000200000;
		pulse_ret;
		wait_for(2, 1'b1);
		chk({29'h0, normal_level}, 32'h3);
		wait_for(2, 1'b0);
		src <= 35'h000200080;
		repeat (10) @(posedge pclk);
		chk({31'h0, normal_req}, 32'h0);
		apb(1'b1, IDX_PRIORITY_SELECT, 16'h0020);
		wait_for(1, 1'b1);
		chk({28'h0, vector_index}, {28'h0, VEC_FAST});
		wait_for(1, 1'b0);
		@(posedge pclk);
		soft_break <= 1'b1;
		@(posedge pclk);
		soft_break <= 1'b0;
		wait_for(0, 1'b1);
		wait_for(0, 1'b0);
		src <= '0;
		rchk(IDX_SERVICE_STATE, 16'h0308);
		pulse_ret;
		rchk(IDX_SERVICE_STATE, 16'h0108);
		pulse_ret;
		rchk(IDX_SERVICE_STATE, 16'h0008);
		pulse_ret;
		rchk(IDX_SERVICE_STATE, 16'h0000);
		apb(1'b1, IDX_PRIORITY_SELECT, 16'h0000);
		// Nesting on: a more urgent level may enter over level 3
		apb(1'b1, IDX_MODE_CONTROL, 16'h0001);
		rchk(IDX_MODE_CONTROL, 16'h0001);
		src <= 35'h000200000;
		wait_for(2, 1'b1);
		wait_for(2, 1'b0);
		src <= 35'h000200080;
		wait_for(2, 1'b1);
		chk({29'h0, normal_level}, 32'h1);
		wait_for(2, 1'b0);
		src <= '0;
		rchk(IDX_SERVICE_STATE, 16'h000A);
		pulse_ret;
		rchk(IDX_SERVICE_STATE, 16'h0008);
		pulse_ret;
		rchk(IDX_SERVICE_STATE, 16'h0000);
		apb(1'b1, IDX_MODE_CONTROL, 16'h0000);
	endtask : s_nest

	task s_ext;
		apb(1'b1, IDX_MISC_CONTROL, 16'h2800);
		external_pin_zero <= 1'b1;
		repeat (3) @(posedge pclk);
		external_pin_zero <= 1'b0;
		repeat (20) @(posedge pclk);
		rchk(IDX_STATUS_SUMMARY, 16'h0000);
		external_pin_zero <= 1'b1;
		repeat (30) @(posedge pclk);
		rchk(IDX_STATUS_SUMMARY, 16'h0800);
		apb(1'b1, IDX_STATUS_SUMMARY, 16'h0800);
		rchk(IDX_STATUS_SUMMARY, 16'h0000);
		external_pin_zero <= 1'b0;
		repeat (30) @(posedge pclk);
		rchk(IDX_STATUS_SUMMARY, 16'h0000);
		// Second pin left on falling edge select
		external_pin_one <= 1'b1;
		repeat (30) @(posedge pclk);
		rchk(IDX_STATUS_SUMMARY, 16'h0000);
		external_pin_one <= 1'b0;
		repeat (30) @(posedge pclk);
		rchk(IDX_STATUS_SUMMARY, 16'h1000);
	endtask : s_ext

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		src = '0;
		key_change_event = 1'b0;
		external_pin_zero = 1'b0;
		external_pin_one = 1'b0;
		soft_break = 1'b0;
		return_done = 1'b0;
		hold = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		s_regs;
		s_poll;
		s_map;
		s_nest;
		s_ext;
		finish_test;
	end
endmodule : testbench
